// ===== dv/tilt_sensor_canopen_node_tx_test.sv
// Self-checking bench for the tilt sensor network node
`timescale 1ns/1ns
`default_nettype none
module tilt_sensor_canopen_node_tx_test import tsn_pkg::*;;
    localparam int MS = 10;
    // Default stored address zero means node one
    localparam logic [10:0] SDO_TX = COB_TSDO + 11'h001;
    localparam logic [10:0] PDO_ID = COB_TPDO + 11'h001;
    localparam logic [10:0] BOOT_ID = COB_BOOT + 11'h001;
    logic sys_clk_i;
    logic srst_i;
    logic rx_valid_i;
    tsn_frame_s rx_frame_i;
    logic tx_valid_o;
    logic tx_ready_i;
    tsn_frame_s tx_frame_o;
    logic [15:0] angle_raw_i;
    tsn_state_e node_state_o;
    int fail_count = 0;
    int checks_done = 0;
    int cycles = 0;

    tsn_node #(.MS_TICKS(MS)) uut (
        .sys_clk_i(sys_clk_i), .srst_i(srst_i), .rx_valid_i(rx_valid_i),
        .rx_frame_i(rx_frame_i), .tx_valid_o(tx_valid_o),
        .tx_ready_i(tx_ready_i), .tx_frame_o(tx_frame_o),
        .angle_raw_i(angle_raw_i), .node_state_o(node_state_o));
    tsn_bus_master m (
        .sys_clk_i(sys_clk_i), .rx_valid_o(rx_valid_i),
        .rx_frame_o(rx_frame_i), .tx_ready_o(tx_ready_i),
        .tx_valid_i(tx_valid_o), .tx_frame_i(tx_frame_o));

    initial begin
        sys_clk_i = 1'b0;
        forever #10 sys_clk_i = ~sys_clk_i;
    end

    always @(posedge sys_clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fail_count++;
            tally_and_finish();
        end
    end

    task automatic tally_and_finish();
        if (fail_count == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Polls on the falling edge so the partner's capture has landed
    task automatic expect_tx(input logic [10:0] id, input logic [3:0] dlc,
            input logic [63:0] data, input int lim);
        tsn_frame_s f;
        int n;
        n = 0;
        while (m.got_q.size() == 0 && n < lim) begin
            @(negedge sys_clk_i);
            n++;
        end
        if (m.got_q.size() == 0) begin
            chk(64'h0, 64'h1);
        end else begin
            f = m.got_q.pop_front();
            chk(64'({f.id, f.rtr, f.dlc}), 64'({id, 1'b0, dlc}));
            chk(f.data, data);
        end
    endtask

    task automatic quiet(input int n);
        repeat (n) @(negedge sys_clk_i);
        chk(64'(m.got_q.size()), 64'h0);
    endtask

    task automatic xfer(input logic [7:0] cmd, input logic [15:0] idx,
            input logic [31:0] val, input logic [7:0] rcmd,
            input logic [31:0] rval);
        m.send({COB_RSDO + 11'h001, 1'b0, 4'h8, val, 8'h00, idx, cmd});
        expect_tx(SDO_TX, 4'h8, {rval, 8'h00, idx, rcmd}, 40);
    endtask

    task automatic nmt(input logic [7:0] cmd, input logic [7:0] node,
            input tsn_state_e exp);
        m.send({COB_NMT, 1'b0, 4'h2, 48'h0, node, cmd});
        repeat (3) @(negedge sys_clk_i);
        chk(64'(node_state_o), 64'(exp));
    endtask

    task automatic boot_check();
        chk(64'(node_state_o), 64'(TSN_PREOP));
        expect_tx(BOOT_ID, 4'h1, 64'h0, 10);
    endtask

    task automatic defaults_check();
        m.stall_cycles = 4;
        xfer(SDO_UPLOAD_REQ, OBJ_CYCLIC_PERIOD, 0, 8'h4B, 32'h0);
        xfer(SDO_UPLOAD_REQ, OBJ_NODE_ADDR, 0, 8'h4F, 32'h0);
        xfer(SDO_UPLOAD_REQ, OBJ_BIT_RATE, 0, 8'h4F, 32'h3);
        xfer(SDO_UPLOAD_REQ, OBJ_ANGLE_STEP, 0, 8'h4F, 32'h0A);
        xfer(SDO_UPLOAD_REQ, OBJ_DEVICE_TYPE, 0, 8'h43,
            DEVICE_PROFILE_CODE);
        xfer(8'h23, OBJ_DEVICE_TYPE, 1, SDO_ABORT, ABORT_READ_ONLY);
        xfer(SDO_UPLOAD_REQ, 16'h5000, 0, SDO_ABORT, ABORT_NO_OBJECT);
        xfer(8'h2B, OBJ_ANGLE_VALUE, 1, SDO_ABORT, ABORT_READ_ONLY);
        xfer(8'hA0, OBJ_ANGLE_STEP, 0, SDO_ABORT, ABORT_BAD_CMD);
        m.stall_cycles = 0;
    endtask

    task automatic polled_check();
        logic [7:0] step [4] = '{8'h0A, 8'h01, 8'h64, 8'h0A};
        logic [15:0] div [4] = '{16'h0001, 16'h000A, 16'h0064, 16'h0001};
        @(posedge sys_clk_i);
        angle_raw_i <= 16'h04D2;
        m.send({PDO_ID, 1'b1, 4'h2, 64'h0});
        quiet(10);
        nmt(NMT_START, 8'h00, TSN_OPER);
        xfer(SDO_UPLOAD_REQ, OBJ_ANGLE_VALUE, 0, 8'h4B, 32'h04D2);
        foreach (step[i]) begin
            xfer(8'h2F, OBJ_ANGLE_STEP, {24'h0, step[i]}, 8'h60, 0);
            m.send({PDO_ID, 1'b1, 4'h2, 64'h0});
            expect_tx(PDO_ID, 4'h2, 64'(16'h04D2 / div[i]), 10);
        end
    endtask

    task automatic cyclic_check();
        int n;
        xfer(8'h2B, OBJ_CYCLIC_PERIOD, 32'h2, 8'h60, 0);
        expect_tx(PDO_ID, 4'h2, 64'h04D2, 40);
        n = 0;
        while (m.got_q.size() == 0 && n < 100) begin
            @(negedge sys_clk_i);
            n++;
        end
        chk(64'(n), 64'(2 * MS));
        expect_tx(PDO_ID, 4'h2, 64'h04D2, 2);
        xfer(8'h2B, OBJ_CYCLIC_PERIOD, 32'h0, 8'h60, 0);
        quiet(60);
    endtask

    task automatic sync_check();
        m.send({COB_SYNC, 1'b0, 4'h0, 64'h0});
        quiet(8);
        xfer(8'h2F, OBJ_SYNC_ENABLE, 32'h1, 8'h60, 0);
        xfer(8'h2F, OBJ_SYNC_SKIP, 32'h2, 8'h60, 0);
        for (int i = 0; i < 6; i++) begin
            m.send({COB_SYNC, 1'b0, 4'h0, 64'h0});
            if (i % 3 == 0) begin
                expect_tx(PDO_ID, 4'h2, 64'h04D2, 6);
            end else begin
                quiet(8);
            end
        end
    endtask

    task automatic state_check();
        nmt(NMT_STOP, 8'h00, TSN_STOPPED);
        m.send({COB_RSDO + 11'h001, 1'b0, 4'h8, 64'h0000_0000_0060_0040});
        quiet(12);
        nmt(NMT_START, 8'h00, TSN_STOPPED);
        nmt(NMT_PREOP, 8'h00, TSN_PREOP);
        nmt(NMT_START, 8'h05, TSN_PREOP);
        nmt(NMT_STOP, 8'h01, TSN_STOPPED);
        nmt(NMT_PREOP, 8'h01, TSN_PREOP);
        xfer(8'h2F, OBJ_ANGLE_STEP, 32'h1, 8'h60, 0);
        xfer(8'h2F, OBJ_BIT_RATE, 32'h5, 8'h60, 0);
        nmt(NMT_RESET_COMM, 8'h01, TSN_PREOP);
        expect_tx(BOOT_ID, 4'h1, 64'h0, 10);
        xfer(SDO_UPLOAD_REQ, OBJ_ANGLE_STEP, 0, 8'h4F, 32'h1);
        xfer(SDO_UPLOAD_REQ, OBJ_BIT_RATE, 0, 8'h4F, 32'h5);
        nmt(NMT_RESET_NODE, 8'h00, TSN_PREOP);
        expect_tx(BOOT_ID, 4'h1, 64'h0, 10);
        xfer(SDO_UPLOAD_REQ, OBJ_ANGLE_STEP, 0, 8'h4F, 32'h0A);
        xfer(SDO_UPLOAD_REQ, OBJ_BIT_RATE, 0, 8'h4F, 32'h3);
    endtask

    initial begin
        srst_i = 1'b1;
        angle_raw_i = 16'h0000;
        repeat (5) @(posedge sys_clk_i);
        srst_i <= 1'b0;
        repeat (2) @(negedge sys_clk_i);
        boot_check();
        defaults_check();
        polled_check();
        cyclic_check();
        sync_check();
        state_check();
        tally_and_finish();
    end
endmodule // tilt_sensor_canopen_node_tx_test
`default_nettype wire

// ===== dv/tsn_bus_master.sv
// Bus master model: sends frames to the node and takes its frames
`timescale 1ns/1ns
`default_nettype none
module tsn_bus_master import tsn_pkg::*; (
    input wire logic sys_clk_i,
    output logic rx_valid_o,
    output tsn_frame_s rx_frame_o,
    output logic tx_ready_o,
    input wire logic tx_valid_i,
    input wire tsn_frame_s tx_frame_i
);
    int stall_cycles = 0;
    int wait_cnt = 0;
    tsn_frame_s got_q[$];

    initial begin
        rx_valid_o = 1'b0;
        rx_frame_o = '0;
        tx_ready_o = 1'b0;
    end

    // A slow host holds ready off for stall_cycles plus one clocks after each offer
    always @(posedge sys_clk_i) begin
        if (tx_valid_i && tx_ready_o) begin
            got_q.push_back(tx_frame_i);
            tx_ready_o <= 1'b0;
            wait_cnt <= 0;
        end else if (tx_valid_i) begin
            tx_ready_o <= (wait_cnt >= stall_cycles);
            wait_cnt <= wait_cnt + 1;
        end
    end

    // Idle lines carry the inverted last frame, never a stale copy
    task automatic send(input tsn_frame_s f);
        @(posedge sys_clk_i);
        rx_valid_o <= 1'b1;
        rx_frame_o <= f;
        @(posedge sys_clk_i);
        rx_valid_o <= 1'b0;
        rx_frame_o <= ~f;
    endtask
endmodule // tsn_bus_master
`default_nettype wire

// ===== dv/tsn_node_props.sv
// Concurrent checks on the network node ports
`timescale 1ns/1ns
`default_nettype none
module tsn_node_props import tsn_pkg::*; #(
    parameter int MS_TICKS = MS_CYCLES
) (
    input wire logic sys_clk_i,
    input wire logic srst_i,
    input wire logic rx_valid_i,
    input wire tsn_frame_s rx_frame_i,
    input wire logic tx_valid_o,
    input wire logic tx_ready_i,
    input wire tsn_frame_s tx_frame_o,
    input wire logic [15:0] angle_raw_i,
    input wire tsn_state_e node_state_o
);
    logic nmt_hit;
    logic [7:0] cmd;
    // Broadcast only, the node address is not visible at these ports
    assign nmt_hit = rx_valid_i && rx_frame_i.id == COB_NMT &&
        rx_frame_i.dlc >= 4'h2 && rx_frame_i.data[15:8] == 8'h00;
    assign cmd = rx_frame_i.data[7:0];

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (srst_i);

    sequence reinit_s;
        node_state_o == TSN_INIT ##1 node_state_o == TSN_PREOP;
    endsequence
    sequence boot_s;
        tx_valid_o && tx_frame_o.id[10:7] == 4'hE;
    endsequence

    frame_hold_a: assert property (tx_valid_o && !tx_ready_i |=>
        tx_valid_o && $stable(tx_frame_o)) else $error("frame moved");
    frame_gap_a: assert property (tx_valid_o && tx_ready_i |=>
        !tx_valid_o) else $error("no gap after frame");
    auto_preop_a: assert property ($fell(srst_i) |=>
        node_state_o == TSN_PREOP ##1 boot_s) else $error("no boot");
    start_ok_a: assert property (nmt_hit && cmd == NMT_START &&
        node_state_o == TSN_PREOP |=> node_state_o == TSN_OPER)
        else $error("start not taken");
    start_refused_a: assert property (nmt_hit && cmd == NMT_START &&
        node_state_o == TSN_STOPPED |=> node_state_o == TSN_STOPPED)
        else $error("start left stopped");
    stop_cmd_a: assert property (nmt_hit && cmd == NMT_STOP &&
        node_state_o != TSN_INIT |=> node_state_o == TSN_STOPPED)
        else $error("stop not taken");
    preop_cmd_a: assert property (nmt_hit && cmd == NMT_PREOP &&
        node_state_o inside {TSN_OPER, TSN_STOPPED}
        |=> node_state_o == TSN_PREOP) else $error("preop not taken");
    reset_cmd_a: assert property (nmt_hit &&
        (cmd == NMT_RESET_NODE || cmd == NMT_RESET_COMM) &&
        node_state_o != TSN_INIT |=> reinit_s ##[1:12] boot_s)
        else $error("reset sequence wrong");
    pdo_gate_a: assert property ($rose(tx_valid_o) &&
        tx_frame_o.id[10:7] == 4'h3 |-> node_state_o == TSN_OPER)
        else $error("process data outside operational");
    sdo_gate_a: assert property ($rose(tx_valid_o) &&
        tx_frame_o.id[10:7] == 4'hB |->
        node_state_o inside {TSN_PREOP, TSN_OPER})
        else $error("parameter reply in wrong state");
endmodule // tsn_node_props

bind tsn_node tsn_node_props #(.MS_TICKS(MS_TICKS)) u_props (
    .sys_clk_i(sys_clk_i), .srst_i(srst_i), .rx_valid_i(rx_valid_i),
    .rx_frame_i(rx_frame_i), .tx_valid_o(tx_valid_o),
    .tx_ready_i(tx_ready_i), .tx_frame_o(tx_frame_o),
    .angle_raw_i(angle_raw_i), .node_state_o(node_state_o));
`default_nettype wire

// ===== rtl/tsn_angle_scaler.sv
// Angle scaling stage: resamples the raw angle every clock
`timescale 1ns/1ns
`default_nettype none
module tsn_angle_scaler import tsn_pkg::*; (
    input wire logic sys_clk_i,
    input wire logic srst_i,
    input wire logic [15:0] angle_raw_i,
    input wire logic [7:0] step_sel_i,
    output logic [15:0] scaled_o
);
    logic [15:0] scaled_q;
    logic [15:0] scaled_d;

    // Raw input is in hundredths of a degree; coarser steps divide it down
    always_comb begin
        if (step_sel_i == STEP_HUNDREDTH) begin
            scaled_d = angle_raw_i;
        end else if (step_sel_i == STEP_TENTH) begin
            scaled_d = angle_raw_i / 16'd10;
        end else begin
            scaled_d = angle_raw_i / 16'd100;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            scaled_q <= 16'h0000;
        end else begin
            scaled_q <= scaled_d;
        end
    end

    assign scaled_o = scaled_q;
endmodule // tsn_angle_scaler
`default_nettype wire

// ===== rtl/tsn_node.sv
// Network node: state machine, parameter service and angle transmission
`timescale 1ns/1ns
`default_nettype none
module tsn_node import tsn_pkg::*; #(
    parameter int MS_TICKS = MS_CYCLES
) (
    input wire logic sys_clk_i,
    input wire logic srst_i,
    input wire logic rx_valid_i,
    input wire tsn_frame_s rx_frame_i,
    output logic tx_valid_o,
    input wire logic tx_ready_i,
    output tsn_frame_s tx_frame_o,
    input wire logic [15:0] angle_raw_i,
    output tsn_state_e node_state_o
);
    tsn_state_e state_q, state_d;
    logic [6:0] node_id_q, node_id_d;
    logic [15:0] period_q, period_d;
    logic [7:0] node_addr_q, node_addr_d;
    logic [7:0] bit_rate_q, bit_rate_d;
    logic [7:0] step_q, step_d;
    logic [7:0] skip_q, skip_d;
    logic [7:0] sync_en_q, sync_en_d;
    logic [7:0] skip_cnt_q, skip_cnt_d;
    logic [15:0] tick_q, tick_d;
    logic [15:0] ms_q, ms_d;
    logic boot_pend_q, boot_pend_d;
    logic pdo_pend_q, pdo_pend_d;
    logic sdo_pend_q, sdo_pend_d;
    logic [15:0] pdo_val_q, pdo_val_d;
    logic [63:0] sdo_data_q, sdo_data_d;
    logic tx_busy_q, tx_busy_d;
    tsn_frame_s tx_q, tx_d;
    logic [15:0] angle_scaled;
    logic [7:0] rx_b0, rx_b1, rx_sub;
    logic [15:0] rx_idx;
    logic [31:0] rx_val;
    logic [1:0] obj_len;
    logic pdo_fire;

    tsn_angle_scaler u_scaler (
        .sys_clk_i(sys_clk_i),
        .srst_i(srst_i),
        .angle_raw_i(angle_raw_i),
        .step_sel_i(step_q),
        .scaled_o(angle_scaled)
    );

    // Length of an object at sub-index zero, LEN_NONE when absent
    function automatic logic [1:0] len_of(input logic [15:0] idx,
                                         input logic [7:0] sub);
        if (sub != 8'h00) begin
            len_of = LEN_NONE;
        end else if (idx == OBJ_DEVICE_TYPE) begin
            len_of = LEN_4;
        end else if (idx == OBJ_CYCLIC_PERIOD || idx == OBJ_ANGLE_VALUE) begin
            len_of = LEN_2;
        end else if (idx == OBJ_SYNC_SKIP || idx == OBJ_SYNC_ENABLE ||
                     idx == OBJ_NODE_ADDR || idx == OBJ_BIT_RATE ||
                     idx == OBJ_ANGLE_STEP) begin
            len_of = LEN_1;
        end else begin
            len_of = LEN_NONE;
        end
    endfunction

    // Identifier of a node-specific message
    function automatic logic [10:0] cob(input logic [10:0] base,
                                        input logic [6:0] id);
        cob = base + {4'h0, id};
    endfunction

    assign rx_b0 = rx_frame_i.data[7:0];
    assign rx_b1 = rx_frame_i.data[15:8];
    assign rx_idx = rx_frame_i.data[23:8];
    assign rx_sub = rx_frame_i.data[31:24];
    assign rx_val = rx_frame_i.data[63:32];
    assign obj_len = len_of(rx_idx, rx_sub);

    always_comb begin
        state_d = state_q;
        node_id_d = node_id_q;
        period_d = period_q;
        node_addr_d = node_addr_q;
        bit_rate_d = bit_rate_q;
        step_d = step_q;
        skip_d = skip_q;
        sync_en_d = sync_en_q;
        skip_cnt_d = skip_cnt_q;
        tick_d = tick_q;
        ms_d = ms_q;
        boot_pend_d = boot_pend_q;
        pdo_pend_d = pdo_pend_q;
        sdo_pend_d = sdo_pend_q;
        pdo_val_d = pdo_val_q;
        sdo_data_d = sdo_data_q;
        tx_busy_d = tx_busy_q;
        tx_d = tx_q;
        pdo_fire = 1'b0;

        // Transmit stage first, so a pending set later in this cycle wins
        if (tx_busy_q && tx_ready_i) begin
            tx_busy_d = 1'b0;
        end else if (!tx_busy_q) begin
            if (boot_pend_q) begin
                tx_d = '{id: cob(COB_BOOT, node_id_q), rtr: 1'b0,
                         dlc: 4'd1, data: 64'h0};
                tx_busy_d = 1'b1;
                boot_pend_d = 1'b0;
            end else if (sdo_pend_q) begin
                tx_d = '{id: cob(COB_TSDO, node_id_q), rtr: 1'b0,
                         dlc: 4'd8, data: sdo_data_q};
                tx_busy_d = 1'b1;
                sdo_pend_d = 1'b0;
            end else if (pdo_pend_q && state_q == TSN_OPER) begin
                // Node id sits in the identifier, so arbitration orders
                // replies from several nodes with no local scheduling
                tx_d = '{id: cob(COB_TPDO, node_id_q), rtr: 1'b0,
                         dlc: 4'd2, data: {48'h0, pdo_val_q}};
                tx_busy_d = 1'b1;
                pdo_pend_d = 1'b0;
            end
        end

        // Millisecond base for the cyclic timer
        if (tick_q == 16'(MS_TICKS - 1)) begin
            tick_d = 16'h0000;
        end else begin
            tick_d = tick_q + 16'h0001;
        end
        if (state_q != TSN_OPER || period_q == 16'h0000) begin
            ms_d = 16'h0000;
        end else if (tick_q == 16'(MS_TICKS - 1)) begin
            if (ms_q + 16'h0001 >= period_q) begin
                ms_d = 16'h0000;
                pdo_fire = 1'b1;
            end else begin
                ms_d = ms_q + 16'h0001;
            end
        end

        if (state_q == TSN_INIT) begin
            node_id_d = 7'(node_addr_q + 8'h01);
            boot_pend_d = 1'b1;
            pdo_pend_d = 1'b0;
            sdo_pend_d = 1'b0;
            skip_cnt_d = 8'h00;
            state_d = TSN_PREOP;
        end else if (rx_valid_i) begin
            if (rx_frame_i.id == COB_NMT && rx_frame_i.dlc >= 4'd2 &&
                (rx_b1 == 8'h00 || rx_b1 == {1'b0, node_id_q})) begin
                case (rx_b0)
                    NMT_START: begin
                        if (state_q == TSN_PREOP) begin
                            state_d = TSN_OPER;
                        end
                    end
                    NMT_STOP: begin
                        if (state_q != TSN_STOPPED) begin
                            state_d = TSN_STOPPED;
                        end
                    end
                    NMT_PREOP: begin
                        state_d = TSN_PREOP;
                    end
                    NMT_RESET_NODE: begin
                        // Application parameters return to defaults
                        period_d = RST_CYCLIC_PERIOD;
                        node_addr_d = RST_NODE_ADDR;
                        bit_rate_d = RST_BIT_RATE;
                        step_d = RST_ANGLE_STEP;
                        skip_d = RST_SYNC_SKIP;
                        sync_en_d = RST_SYNC_ENABLE;
                        state_d = TSN_INIT;
                    end
                    NMT_RESET_COMM: begin
                        state_d = TSN_INIT;
                    end
                    default: begin
                    end
                endcase
            end else if (rx_frame_i.id == COB_SYNC && state_q == TSN_OPER &&
                         sync_en_q != 8'h00) begin
                if (skip_cnt_q == 8'h00) begin
                    pdo_fire = 1'b1;
                    skip_cnt_d = skip_q;
                end else begin
                    skip_cnt_d = skip_cnt_q - 8'h01;
                end
            end else if (rx_frame_i.id == cob(COB_TPDO, node_id_q) &&
                         rx_frame_i.rtr && state_q == TSN_OPER) begin
                pdo_fire = 1'b1;
            end else if (rx_frame_i.id == cob(COB_RSDO, node_id_q) &&
                         // A reply leaving this cycle frees the slot
                         !rx_frame_i.rtr && !sdo_pend_d &&
                         (state_q == TSN_PREOP ||
                          state_q == TSN_OPER)) begin
                sdo_pend_d = 1'b1;
                sdo_data_d = {32'h0, rx_sub, rx_idx, SDO_ABORT};
                if (obj_len == LEN_NONE) begin
                    sdo_data_d[63:32] = ABORT_NO_OBJECT;
                end else if (rx_b0 == SDO_UPLOAD_REQ) begin
                    if (obj_len == LEN_4) begin
                        sdo_data_d[7:0] = SDO_UP_REPLY_4;
                        sdo_data_d[63:32] = DEVICE_PROFILE_CODE;
                    end else if (obj_len == LEN_2) begin
                        sdo_data_d[7:0] = SDO_UP_REPLY_2;
                        sdo_data_d[47:32] = (rx_idx == OBJ_ANGLE_VALUE) ?
                                            angle_scaled : period_q;
                    end else begin
                        sdo_data_d[7:0] = SDO_UP_REPLY_1;
                        if (rx_idx == OBJ_SYNC_SKIP) begin
                            sdo_data_d[39:32] = skip_q;
                        end else if (rx_idx == OBJ_SYNC_ENABLE) begin
                            sdo_data_d[39:32] = sync_en_q;
                        end else if (rx_idx == OBJ_NODE_ADDR) begin
                            sdo_data_d[39:32] = node_addr_q;
                        end else if (rx_idx == OBJ_BIT_RATE) begin
                            sdo_data_d[39:32] = bit_rate_q;
                        end else begin
                            sdo_data_d[39:32] = step_q;
                        end
                    end
                end else if (rx_b0[7:5] == SDO_DOWN_CCS) begin
                    if (rx_idx == OBJ_DEVICE_TYPE ||
                        rx_idx == OBJ_ANGLE_VALUE) begin
                        sdo_data_d[63:32] = ABORT_READ_ONLY;
                    end else begin
                        sdo_data_d[7:0] = SDO_DOWN_ACK;
                        if (rx_idx == OBJ_CYCLIC_PERIOD) begin
                            period_d = rx_val[15:0];
                        end else if (rx_idx == OBJ_SYNC_SKIP) begin
                            skip_d = rx_val[7:0];
                            skip_cnt_d = 8'h00;
                        end else if (rx_idx == OBJ_SYNC_ENABLE) begin
                            sync_en_d = rx_val[7:0];
                        end else if (rx_idx == OBJ_NODE_ADDR) begin
                            // New address takes hold at the next communication reset; a node reset restores the default
                            node_addr_d = rx_val[7:0];
                        end else if (rx_idx == OBJ_BIT_RATE) begin
                            bit_rate_d = rx_val[7:0];
                        end else begin
                            step_d = rx_val[7:0];
                        end
                    end
                end else begin
                    sdo_data_d[63:32] = ABORT_BAD_CMD;
                end
            end
        end

        // Sampled at the trigger, so a queued frame keeps its moment
        if (pdo_fire && state_d == TSN_OPER) begin
            pdo_pend_d = 1'b1;
            pdo_val_d = angle_scaled;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            state_q <= TSN_INIT;
            node_id_q <= 7'h01;
            period_q <= RST_CYCLIC_PERIOD;
            node_addr_q <= RST_NODE_ADDR;
            bit_rate_q <= RST_BIT_RATE;
            step_q <= RST_ANGLE_STEP;
            skip_q <= RST_SYNC_SKIP;
            sync_en_q <= RST_SYNC_ENABLE;
            skip_cnt_q <= 8'h00;
            tick_q <= 16'h0000;
            ms_q <= 16'h0000;
            boot_pend_q <= 1'b0;
            pdo_pend_q <= 1'b0;
            sdo_pend_q <= 1'b0;
            pdo_val_q <= 16'h0000;
            sdo_data_q <= 64'h0;
            tx_busy_q <= 1'b0;
            tx_q <= '0;
        end else begin
            state_q <= state_d;
            node_id_q <= node_id_d;
            period_q <= period_d;
            node_addr_q <= node_addr_d;
            bit_rate_q <= bit_rate_d;
            step_q <= step_d;
            skip_q <= skip_d;
            sync_en_q <= sync_en_d;
            skip_cnt_q <= skip_cnt_d;
            tick_q <= tick_d;
            ms_q <= ms_d;
            boot_pend_q <= boot_pend_d;
            pdo_pend_q <= pdo_pend_d;
            sdo_pend_q <= sdo_pend_d;
            pdo_val_q <= pdo_val_d;
            sdo_data_q <= sdo_data_d;
            tx_busy_q <= tx_busy_d;
            tx_q <= tx_d;
        end
    end

    assign tx_valid_o = tx_busy_q;
    assign tx_frame_o = tx_q;
    assign node_state_o = state_q;
endmodule // tsn_node
`default_nettype wire

// ===== rtl/tsn_pkg.sv
// Shared constants and frame type for the tilt sensor network node
package tsn_pkg;

    typedef struct packed {
        logic [10:0] id;
        logic rtr;
        logic [3:0] dlc;
        logic [63:0] data;
    } tsn_frame_s;

    typedef enum logic [1:0] {
        TSN_INIT,
        TSN_PREOP,
        TSN_OPER,
        TSN_STOPPED
    } tsn_state_e;

    // Clock and millisecond tick
    localparam int CLK_HZ = 50_000_000;
    localparam int MS_TIME_MS = 1;
    localparam int MS_CYCLES = CLK_HZ / 1000 * MS_TIME_MS;

    // Network management command bytes
    localparam logic [7:0] NMT_START = 8'h01;
    localparam logic [7:0] NMT_STOP = 8'h02;
    localparam logic [7:0] NMT_PREOP = 8'h80;
    localparam logic [7:0] NMT_RESET_NODE = 8'h81;
    localparam logic [7:0] NMT_RESET_COMM = 8'h82;

    // Identifier bases, node id (stored address plus one) is added where it applies
    localparam logic [10:0] COB_NMT = 11'h000;
    localparam logic [10:0] COB_SYNC = 11'h080;
    localparam logic [10:0] COB_TPDO = 11'h180;
    localparam logic [10:0] COB_TSDO = 11'h580;
    localparam logic [10:0] COB_RSDO = 11'h600;
    localparam logic [10:0] COB_BOOT = 11'h700;

    // Parameter service command bytes
    localparam logic [7:0] SDO_UPLOAD_REQ = 8'h40;
    localparam logic [7:0] SDO_UP_REPLY_4 = 8'h43;
    localparam logic [7:0] SDO_UP_REPLY_2 = 8'h4B;
    localparam logic [7:0] SDO_UP_REPLY_1 = 8'h4F;
    localparam logic [7:0] SDO_DOWN_ACK = 8'h60;
    localparam logic [7:0] SDO_ABORT = 8'h80;
    localparam logic [2:0] SDO_DOWN_CCS = 3'h1;
    localparam logic [31:0] ABORT_BAD_CMD = 32'h0504_0001;
    localparam logic [31:0] ABORT_READ_ONLY = 32'h0601_0002;
    localparam logic [31:0] ABORT_NO_OBJECT = 32'h0602_0000;

    // Object indices
    localparam logic [15:0] OBJ_DEVICE_TYPE = 16'h1000;
    localparam logic [15:0] OBJ_CYCLIC_PERIOD = 16'h2200;
    localparam logic [15:0] OBJ_SYNC_SKIP = 16'h2201;
    localparam logic [15:0] OBJ_SYNC_ENABLE = 16'h2202;
    localparam logic [15:0] OBJ_NODE_ADDR = 16'h3000;
    localparam logic [15:0] OBJ_BIT_RATE = 16'h3001;
    localparam logic [15:0] OBJ_ANGLE_STEP = 16'h6000;
    localparam logic [15:0] OBJ_ANGLE_VALUE = 16'h6010;

    // Object lengths as coded by the length lookup
    localparam logic [1:0] LEN_NONE = 2'h0;
    localparam logic [1:0] LEN_1 = 2'h1;
    localparam logic [1:0] LEN_2 = 2'h2;
    localparam logic [1:0] LEN_4 = 2'h3;

    // Values after reset
    localparam logic [15:0] RST_CYCLIC_PERIOD = 16'h0000;
    localparam logic [7:0] RST_NODE_ADDR = 8'h00;
    localparam logic [7:0] RST_BIT_RATE = 8'h03;
    localparam logic [7:0] RST_ANGLE_STEP = 8'h0A;
    localparam logic [7:0] RST_SYNC_SKIP = 8'h00;
    localparam logic [7:0] RST_SYNC_ENABLE = 8'h00;
    // Arbitrary profile code, not tied to any product
    localparam logic [31:0] DEVICE_PROFILE_CODE = 32'h0001_0000;

    // Step select codes understood by the scaler
    localparam logic [7:0] STEP_HUNDREDTH = 8'h0A;
    localparam logic [7:0] STEP_TENTH = 8'h01;

endpackage
